// [bst_ctrl_model.sv]
/*
  Board test controller model that drives the test link. Assumes the bench
  calls one task at a time; the test clock only runs inside the tasks.
*/
module bst_ctrl_model (
  // link, driven by the controller
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  // link, driven by the device
  input  wire logic tdo,
  input  wire logic tdoEn
);
  timeunit 1ns;
  timeprecision 1ns;

  // the port is held in reset with the clock still until released
  initial begin
    tck    = 1'b0;
    trst_n = 1'b1;
    tms    = 1'b1;
    tdi    = 1'b0;
    // a clean falling edge, so reset cannot race the design at time 0
    #1 trst_n = 1'b0;
  end

  // one clock: inputs set while low, data out taken at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    q = tdo;
    #32 tck = 1'b0;
  endtask : step

  // asynchronous reset level, clock standing still
  task automatic setReset(input logic v);
    trst_n = v;
  endtask : setReset

  // five high mode bits reach reset from any state
  task automatic tmsReset();
    logic q;
    repeat (5) step(1'b1, tdi, q);
  endtask : tmsReset

  // reset state to idle
  task automatic toIdle();
    logic q;
    step(1'b0, tdi, q);
  endtask : toIdle

  // idle, select, capture, n shift bits lsb first, update, idle
  task automatic shift(input logic ir, input int n,
                       input logic [47:0] din, output logic [47:0] dout);
    logic q;
    dout = '0;
    step(1'b1, tdi, q);
    if (ir) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
    step(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    // a released line must not look as if it still held its last bit
    tdi = ~tdi;
    step(1'b1, tdi, q);
    step(1'b0, tdi, q);
  endtask : shift
endmodule : bst_ctrl_model

// [bst_pkg.sv]
/*
  Constants, TAP state type and instruction decoding for the boundary-scan
  test access port. Assumes a single compile unit where every design file
  imports this package.
*/
// How it works
// R1 - BYPASS puts a single flip-flop between test data in and out
// R2 - EXTEST lets the boundary register drive and observe the pins
// R3 - SAMPLE captures pin values without disturbing normal operation
// R4 - SAMPLE also preloads shifted values into the boundary update latches
// R5 - CLAMP selects bypass while boundary register keeps driving pins
// R6 - IDCODE puts the identification register on the serial path
// R7 - identification register loads its code in Capture-DR, then shifts out
// R8 - identification register is 32 bits: maker, part and version fields
// R9 - bit 31 nearest data in, bit 0 nearest data out, bit 0 first
// R10 - test reset low forces Test-Logic-Reset at once, without test clock
// R11 - Test-Logic-Reset forces the functional IDCODE instruction
// R12 - controller keeps the port in Test-Logic-Reset during normal operation
// R13 - five dedicated pins; controller drives four, device drives data out
// R14 - sixteen-state machine on rising test clock; data out on falling
// R15 - BYPASS all ones, EXTEST all zeros, unused codes select bypass
package bst_pkg;

  // instruction register layout
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;  // [R15]
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] OP_CLAMP  = 4'h2;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h3;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;  // [R15]
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;  // fixed 01 in the low bits

  // identification register
  localparam int ID_W = 32;                       // [R8]
  localparam logic [3:0]  ID_VERSION = 4'h1;      // arbitrary value
  localparam logic [15:0] ID_PART    = 16'h5A3C;  // arbitrary value
  localparam logic [10:0] ID_MAKER   = 11'h2B5;   // arbitrary value
  localparam logic [ID_W-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // reset and capture value, synchroniser depth
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam int   SYNC_STAGES    = 3;

  // the sixteen controller states
  typedef enum logic [3:0] {
    TestLogicReset, RunTestIdle,
    SelectDr, CaptureDr, ShiftDr, Exit1Dr, PauseDr, Exit2Dr, UpdateDr,
    SelectIr, CaptureIr, ShiftIr, Exit1Ir, PauseIr, Exit2Ir, UpdateIr
  } bst_state_t;

  // boundary register is the data path for these instructions
  function automatic logic selBoundary(input logic [IR_W-1:0] op);
    selBoundary = (op == OP_EXTEST) || (op == OP_SAMPLE);
  endfunction : selBoundary

  // pins are driven from the boundary latches for these instructions
  function automatic logic drivesPins(input logic [IR_W-1:0] op);
    drivesPins = (op == OP_EXTEST) || (op == OP_CLAMP);  // [R2] [R5]
  endfunction : drivesPins

  // bypass is the fallback for every code without a register of its own
  function automatic logic selBypassReg(input logic [IR_W-1:0] op);
    selBypassReg = !selBoundary(op) && (op != OP_IDCODE);  // [R15] [R1]
  endfunction : selBypassReg

endpackage : bst_pkg

// [bst_sync.sv]
/*
  Three-stage synchroniser for a bus of levels. Assumes each bit is a level
  that holds for several destination clocks; not suited to wide words.
*/
module bst_sync #(
  parameter int W = 1
) (
  // destination domain
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous levels in, filtered levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import bst_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // stage1 feeds only stage2, so metastability never reaches logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          q[i] <= stage3[i];
        end
      end
    end
  end

endmodule : bst_sync

// [bst_tap.sv]
/*
  Boundary-scan test access port: controller, instruction register, bypass,
  identification and boundary registers, plus the pin multiplexer in the
  system clock domain. Assumes the board controller drives tck, tms, tdi and
  trst_n, and that functional logic offers its pin values on funcOut.
*/
module bst_tap #(
  parameter int IN_W  = 8,
  parameter int OUT_W = 8
) (
  // system domain
  input  wire logic             clk,
  input  wire logic             reset_n,
  // test link, all from the board controller
  input  wire logic             tck,
  input  wire logic             trst_n,
  input  wire logic             tms,
  input  wire logic             tdi,
  // test data out, driven by the device
  output logic                  tdo,
  output logic                  tdoEn,
  // pins under test
  input  wire logic [IN_W-1:0]  pinIn,
  input  wire logic [OUT_W-1:0] funcOut,
  output logic      [OUT_W-1:0] pinOut,
  // current instruction, for observation
  output logic [bst_pkg::IR_W-1:0] instr
);
  import bst_pkg::*;

  localparam int BSR_W = IN_W + OUT_W;

  bst_state_t state;

  logic [IR_W-1:0]  irShift;
  logic             bypassBit;
  logic [ID_W-1:0]  idShift;
  logic [BSR_W-1:0] bsrShift;
  logic [OUT_W-1:0] updateReg;
  logic             updToggle;
  logic             testMode;
  logic [BSR_W-1:0] pinSample;
  logic             serialBit;

  // system domain side of the crossings
  logic             testModeSys;
  logic             updToggleSys;
  logic             updSeen;
  logic [OUT_W-1:0] pinHold;

  // controller
  bst_tap_fsm u_fsm (
    .tck    (tck),
    .trst_n (trst_n),
    .tms    (tms),
    .state  (state)
  );

  // pins and driven outputs are caught on the test clock through three stages and a filter flop
  bst_sync #(
    .W (BSR_W)
  ) u_pinSync (
    .clk   (tck),
    .rst_n (trst_n),
    .d     ({pinIn, pinOut}),
    .q     (pinSample)
  );

  // instruction shift register, fixed pattern captured first
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      irShift <= OP_IDCODE;
    end else if (state == CaptureIr) begin
      irShift <= IR_CAPTURE;
    end else if (state == ShiftIr) begin
      irShift <= {tdi, irShift[IR_W-1:1]};
    end
  end

  // instruction latch, functional code whenever the controller is reset
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      instr <= OP_IDCODE;  // [R11]
    end else if (state == TestLogicReset) begin
      instr <= OP_IDCODE;  // [R11]
    end else if (state == UpdateIr) begin
      instr <= irShift;
    end
  end

  // pin drive mode follows the instruction latch on update, and clears in Test-Logic-Reset
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      testMode <= 1'b0;
    end else if (state == TestLogicReset) begin
      testMode <= 1'b0;
    end else if (state == UpdateIr) begin
      testMode <= drivesPins(irShift);  // [R2] [R5]
    end
  end

  // one-bit bypass path
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bypassBit <= BYPASS_CAPTURE;
    end else if (selBypassReg(instr)) begin
      if (state == CaptureDr) begin
        bypassBit <= BYPASS_CAPTURE;
      end else if (state == ShiftDr) begin
        bypassBit <= tdi;  // [R1] [R5]
      end
    end
  end

  // identification register, loaded in capture, lsb leaves first
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      idShift <= ID_CODE;
    end else if (instr == OP_IDCODE) begin
      if (state == CaptureDr) begin
        idShift <= ID_CODE;  // [R7] [R8]
      end else if (state == ShiftDr) begin
        idShift <= {tdi, idShift[ID_W-1:1]};  // [R9]
      end
    end
  end

  // boundary shift register: capture pins, shift from tdi toward tdo
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bsrShift <= '0;
    end else if (selBoundary(instr)) begin
      if (state == CaptureDr) begin
        bsrShift <= pinSample;  // [R3]
      end else if (state == ShiftDr) begin
        bsrShift <= {tdi, bsrShift[BSR_W-1:1]};
      end
    end
  end

  // update latches; a toggle tells the system domain a new word is ready
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      updateReg <= '0;
      updToggle <= 1'b0;
    end else if (state == UpdateDr && selBoundary(instr)) begin
      updateReg <= bsrShift[OUT_W-1:0];  // [R4] [R2]
      updToggle <= ~updToggle;
    end
  end

  // serial path selection by instruction
  always_comb begin
    if (state == ShiftIr) begin
      serialBit = irShift[0];
    end else if (instr == OP_IDCODE) begin
      serialBit = idShift[0];  // [R6]
    end else if (selBoundary(instr)) begin
      serialBit = bsrShift[0];
    end else begin
      serialBit = bypassBit;  // [R1] [R15]
    end
  end

  // data out changes on the falling edge, so the controller samples it
  // mid-cycle; enabled only while a shift state is active
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tdo   <= serialBit;  // [R13] [R14]
      tdoEn <= (state == ShiftIr) || (state == ShiftDr);
    end
  end

  // mode and update toggle cross into the system clock as levels
  bst_sync #(
    .W (2)
  ) u_ctlSync (
    .clk   (clk),
    .rst_n (reset_n),
    .d     ({testMode, updToggle}),
    .q     ({testModeSys, updToggleSys})
  );

  // copy the update word once its toggle arrives; the word is stable by
  // then because the next update is several test clocks away
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      updSeen <= 1'b0;
      pinHold <= '0;
    end else begin
      updSeen <= updToggleSys;
      if (updSeen != updToggleSys) begin
        pinHold <= updateReg;  // [R4]
      end
    end
  end

  // pins follow functional logic unless a test instruction drives them;
  // sample and preload leave normal operation untouched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= '0;
    end else if (testModeSys) begin
      pinOut <= pinHold;  // [R2] [R5]
    end else begin
      pinOut <= funcOut;  // [R3]
    end
  end

  // checks on the test clock domain
  default clocking cbTest @(posedge tck);
  endclocking
  default disable iff (!trst_n);

  a_bypass_path: assert property (  // [R1]
    (state == ShiftDr && instr == OP_BYPASS) |=> bypassBit == $past(tdi)
  ) else $error("bypass bit did not take tdi");

  a_extest_drive: assert property (  // [R2]
    (state == UpdateIr && irShift == OP_EXTEST) |=> testMode [*2]
  ) else $error("extest did not enable pin drive");

  a_sample_capture: assert property (  // [R3]
    (state == CaptureDr && instr == OP_SAMPLE) |=> bsrShift == $past(pinSample)
  ) else $error("sample did not capture pins");

  a_preload_update: assert property (  // [R4]
    (state == UpdateDr && instr == OP_SAMPLE)
      |=> updateReg == $past(bsrShift[OUT_W-1:0])
  ) else $error("preload did not reach update latch");

  a_clamp_select: assert property (  // [R5]
    (instr == OP_CLAMP && state == ShiftDr) |-> serialBit == bypassBit
  ) else $error("clamp path is not bypass");

  a_idcode_path: assert property (  // [R6]
    (instr == OP_IDCODE && state == ShiftDr) |-> serialBit == idShift[0]
  ) else $error("idcode register not on serial path");

  a_idcode_load: assert property (  // [R7]
    (state == CaptureDr && instr == OP_IDCODE) |=> idShift == ID_CODE
  ) else $error("identification code not captured");

  a_idcode_order: assert property (  // [R9]
    (state == CaptureDr && instr == OP_IDCODE) ##1 (state == ShiftDr)
      |=> idShift[ID_W-2:0] == ID_CODE[ID_W-1:1]
  ) else $error("identification code not shifted lsb first");

  a_reset_instr: assert property (  // [R11]
    (state == TestLogicReset) |=> (instr == OP_IDCODE && !testMode)
  ) else $error("reset state left a test instruction");

  a_tms_reset: assert property (  // [R14]
    tms [*5] |=> state == TestLogicReset
  ) else $error("five tms highs did not reach reset");

  a_unused_bypass: assert property (  // [R15]
    (state == ShiftDr && !selBoundary(instr) && instr != OP_IDCODE)
      |-> serialBit == bypassBit
  ) else $error("unused code not routed to bypass");

  a_tdo_enable: assert property (  // [R13]
    (state == ShiftDr) ##1 (state == ShiftDr) |-> tdoEn
  ) else $error("tdo not enabled while shifting");

  // serial and capture paths, checked edge by edge on the test clock;
  // tdo seen at a rising edge is what the last falling edge launched
  a_bypass_capture: assert property (  // [R1]
    (state == CaptureDr && selBypassReg(instr))
      |=> bypassBit == BYPASS_CAPTURE
  ) else $error("bypass bit not cleared in capture");

  a_bypass_tdo: assert property (  // [R1]
    (state == ShiftDr && selBypassReg(instr)) |-> tdo == bypassBit
  ) else $error("bypass bit not on tdo");

  a_bypass_shift: assert property (  // [R15]
    (state == ShiftDr && selBypassReg(instr))
      |=> bypassBit == $past(tdi)
  ) else $error("unused code bypass did not take tdi");

  a_bsr_shift: assert property (  // [R2]
    (state == ShiftDr && selBoundary(instr))
      |=> bsrShift[BSR_W-1] == $past(tdi)
  ) else $error("boundary register did not take tdi");

  a_bsr_tdo: assert property (  // [R2]
    (state == ShiftDr && selBoundary(instr)) |-> tdo == bsrShift[0]
  ) else $error("boundary register not on tdo");

  a_extest_update: assert property (  // [R2]
    (state == UpdateDr && instr == OP_EXTEST)
      |=> updateReg == $past(bsrShift[OUT_W-1:0])
  ) else $error("extest update latch not loaded");

  a_sample_nodrive: assert property (  // [R3]
    (state == UpdateIr && irShift == OP_SAMPLE) |=> !testMode
  ) else $error("sample drives the pins");

  a_preload_toggle: assert property (  // [R4]
    (state == UpdateDr && instr == OP_SAMPLE)
      |=> updToggle != $past(updToggle)
  ) else $error("preload not signalled to system side");

  a_clamp_drive: assert property (  // [R5]
    (state == UpdateIr && irShift == OP_CLAMP) |=> testMode
  ) else $error("clamp does not drive the pins");

  a_clamp_keep: assert property (  // [R5]
    (state == UpdateDr && instr == OP_CLAMP)
      |=> updateReg == $past(updateReg)
  ) else $error("clamp changed the update latch");

  a_idcode_tdo: assert property (  // [R6]
    (state == ShiftDr && instr == OP_IDCODE) |-> tdo == idShift[0]
  ) else $error("identification bit not on tdo");

  a_id_shift: assert property (  // [R9]
    (state == ShiftDr && instr == OP_IDCODE) |=> idShift[ID_W-1] == $past(tdi)
  ) else $error("identification register did not take tdi");

  a_tdo_quiet: assert property (  // [R13]
    (state != ShiftDr && state != ShiftIr) |-> !tdoEn
  ) else $error("tdo driven outside a shift state");

  a_ir_capture: assert property (  // [R14]
    (state == CaptureIr) |=> irShift == IR_CAPTURE
  ) else $error("instruction capture pattern wrong");

  a_ir_shift: assert property (  // [R14]
    (state == ShiftIr) |=> irShift[IR_W-1] == $past(tdi)
  ) else $error("instruction register did not take tdi");

  a_ir_tdo: assert property (  // [R14]
    (state == ShiftIr) |-> tdo == irShift[0]
  ) else $error("instruction register not on tdo");

  a_ir_update: assert property (  // [R14]
    (state == UpdateIr) |=> instr == $past(irShift)
  ) else $error("instruction not latched on update");

  a_tlr_hold: assert property (  // [R14]
    (state == TestLogicReset && tms) |=> state == TestLogicReset
  ) else $error("reset state left with tms high");

endmodule : bst_tap

// [bst_tap_fsm.sv]
/*
  TAP controller state machine. Assumes the test clock is the clock of this
  logic and the test reset pin is its asynchronous reset.
*/
module bst_tap_fsm (
  // test link
  input  wire logic          tck,
  input  wire logic          trst_n,
  input  wire logic          tms,
  // current state
  output bst_pkg::bst_state_t state
);
  import bst_pkg::*;

  bst_state_t next_state;

  // state register; test reset wins at once, with no test clock edge
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state <= TestLogicReset;  // [R10]
    end else begin
      state <= next_state;  // [R14]
    end
  end

  // standard transitions steered by the mode select pin
  always_comb begin
    unique case (state)
      TestLogicReset: next_state = tms ? TestLogicReset : RunTestIdle;
      RunTestIdle:    next_state = tms ? SelectDr : RunTestIdle;
      SelectDr:       next_state = tms ? SelectIr : CaptureDr;
      CaptureDr:      next_state = tms ? Exit1Dr  : ShiftDr;
      ShiftDr:        next_state = tms ? Exit1Dr  : ShiftDr;
      Exit1Dr:        next_state = tms ? UpdateDr : PauseDr;
      PauseDr:        next_state = tms ? Exit2Dr  : PauseDr;
      Exit2Dr:        next_state = tms ? UpdateDr : ShiftDr;
      UpdateDr:       next_state = tms ? SelectDr : RunTestIdle;
      SelectIr:       next_state = tms ? TestLogicReset : CaptureIr;
      CaptureIr:      next_state = tms ? Exit1Ir  : ShiftIr;
      ShiftIr:        next_state = tms ? Exit1Ir  : ShiftIr;
      Exit1Ir:        next_state = tms ? UpdateIr : PauseIr;
      PauseIr:        next_state = tms ? Exit2Ir  : PauseIr;
      Exit2Ir:        next_state = tms ? UpdateIr : ShiftIr;
      UpdateIr:       next_state = tms ? SelectDr : RunTestIdle;
    endcase
  end

endmodule : bst_tap_fsm

// [tb_bst_tap.sv]
/*
  Self-checking bench for the boundary-scan port: a row per instruction,
  then reset cases. Assumes the controller model owns the test link.
*/
module tb_bst_tap;
  import bst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [3:0]  op;
    int          len;
    logic [47:0] cap;
    logic [47:0] pat;
    logic [7:0]  pins;
  } bst_row_t;

  logic        clk;
  logic        reset_n;
  logic        tck;
  logic        trst_n;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdoEn;
  logic [7:0]  pinIn;
  logic [7:0]  funcOut;
  logic [7:0]  pinOut;
  logic [3:0]  instr;
  logic [47:0] got;
  bst_row_t    rows [7];
  int          nFail;
  int          nCompared;
  int          cycles;

  bst_tap #(.IN_W(8), .OUT_W(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn),
    .funcOut(funcOut), .pinOut(pinOut), .instr(instr)
  );

  bst_ctrl_model ctrl_u (
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn)
  );

  // 20 MHz system clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // a hang counts as a mismatch; the run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      nFail++;
      summarize();
    end
  end

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask : waitClk

  task automatic check(input logic [47:0] g, input logic [47:0] e);
    nCompared++;
    if (g !== e) begin
      nFail++;
      $display("FAIL t=%0t got %h want %h", $time, g, e);
    end
  endtask : check

  // captured bits come first, then the pattern delayed by the path length
  function automatic logic [47:0] expDr(input bst_row_t r);
    logic [47:0] m;
    m = (48'h1 << r.len) - 48'h1;
    expDr = (r.pat << r.len) | (r.cap & m);
  endfunction : expDr

  task automatic summarize();
    $display("compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    reset_n = 1'b0;
    pinIn   = 8'h3C;
    funcOut = 8'hA5;
    // sample preloads C3, extest drives it then updates to 96, clamp keeps
    rows[0] = '{OP_BYPASS, 1, 48'h0, 48'h0000_1234_5678, 8'hA5};
    rows[1] = '{4'h7, 1, 48'h0, 48'h9ABC_DEF0_1357, 8'hA5};
    rows[2] = '{OP_IDCODE, 32, {16'h0, ID_CODE}, 48'h2468_ACE0_0F0F, 8'hA5};
    rows[3] = '{OP_SAMPLE, 16, 48'h3CA5, 48'h00C3_0000_0000, 8'hA5};
    rows[4] = '{OP_EXTEST, 16, 48'h3CC3, 48'h0096_1111_2222, 8'h96};
    rows[5] = '{OP_CLAMP, 1, 48'h0, 48'h5555_AAAA_3333, 8'h96};
    rows[6] = '{OP_BYPASS, 1, 48'h0, 48'h0F0F_F0F0_7777, 8'hA5};
    waitClk(5);
    check({40'h0, pinOut}, 48'h0);
    check({44'h0, instr}, {44'h0, OP_IDCODE});
    check({47'h0, tdoEn}, 48'h0);
    waitClk(15);
    reset_n = 1'b1;
    ctrl_u.setReset(1'b1);
    waitClk(2);
    check({40'h0, pinOut}, 48'hA5);
    ctrl_u.toIdle();
    for (int i = 0; i < 7; i++) begin
      ctrl_u.shift(1'b1, 4, {44'h0, rows[i].op}, got);
      check(got, {44'h0, IR_CAPTURE});
      check({44'h0, instr}, {44'h0, rows[i].op});
      waitClk(10);
      // pins moved while the test clock stood; let them pass the sync flops
      repeat (3) ctrl_u.toIdle();
      ctrl_u.shift(1'b0, 48, rows[i].pat, got);
      check(got, expDr(rows[i]));
      waitClk(10);
      check({40'h0, pinOut}, {40'h0, rows[i].pins});
    end
    // reset pin acts with the test clock stopped, mid-run
    ctrl_u.setReset(1'b0);
    waitClk(2);
    check({44'h0, instr}, {44'h0, OP_IDCODE});
    ctrl_u.setReset(1'b1);
    ctrl_u.toIdle();
    check({47'h0, tdoEn}, 48'h0);
    ctrl_u.shift(1'b0, 32, 48'h0, got);
    check(got, {16'h0, ID_CODE});
    // five high mode bits restore the functional instruction
    ctrl_u.shift(1'b1, 4, {44'h0, OP_BYPASS}, got);
    ctrl_u.tmsReset();
    check({44'h0, instr}, {44'h0, OP_IDCODE});
    // functional values pass while the port rests in reset
    funcOut = 8'h5A;
    waitClk(3);
    check({40'h0, pinOut}, 48'h5A);
    summarize();
  end
endmodule : tb_bst_tap
